// *** hdl/cell_array_pkg.sv ***
// Purpose: shared constants and types for the output cell array
// Assumes: eight cells, three configuration bits per cell, two global bits
// Notes: mode encoding from the two global bits is fixed here
package cell_array_pkg;
  localparam int NUM_CELLS = 8;
  localparam int CFG_BITS = 24;
  // register map, byte addresses
  localparam logic [7:0] GLOBAL_OFS = 8'h00;
  localparam logic [7:0] POLARITY_OFS = 8'h04;
  localparam logic [7:0] DIRECTION_OFS = 8'h08;
  localparam logic [7:0] DRIVE_OFS = 8'h0c;
  localparam logic [7:0] SUM_OFS = 8'h10;
  localparam logic [7:0] ENABLE_OFS = 8'h14;
  localparam logic [7:0] PRELOAD_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  localparam logic [7:0] PINS_OFS = 8'h20;
  // field positions in the global register
  localparam int SYNC_BIT = 0;
  localparam int MODE_BIT = 1;
  // reset values
  localparam logic [1:0] GLOBAL_RST = 2'h0;
  localparam logic [7:0] CELL_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  // outermost and centre cells
  localparam int OUTER_LO = 0;
  localparam int OUTER_HI = 7;
  localparam int CENTRE_LO = 3;
  localparam int CENTRE_HI = 4;
  typedef enum logic [1:0] {MODE_SIMPLE, MODE_COMPLEX, MODE_REGISTERED} mode_t;
  // one cell's three configuration bits
  typedef struct packed {
    logic polarity;
    logic direction;
    logic drive_type;
  } cell_cfg_t;
  // pin pair, out and oe, for the eight cell pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;
endpackage

// *** hdl/output_cell_array.sv ***
// Purpose: eight configurable output cells with an AHB-Lite register file
// Assumes: hclk 25 MHz; the shared clock and enable pins are sampled by two flops
// Notes: sum inputs stand in for the product-term sums of the array
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module output_cell_array (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] term_sum,
  input wire logic [7:0] term_enable,
  input wire logic shared_clk_pin,
  input wire logic shared_oe_n_pin,
  input wire logic [7:0] cell_pin_in,
  output logic [7:0] cell_pin_out,
  output logic [7:0] cell_pin_oe,
  output logic [7:0] array_feedback,
  output logic [1:0] array_extra_in
);
  logic [1:0] global_r;
  logic [7:0] polarity_r, direction_r, drive_r, sum_r, enable_r;
  logic [7:0] cell_reg_r;
  logic [7:0] pins_s1_r, pins_s2_r;
  logic [1:0] ctl_s1_r, ctl_s2_r, ctl_d_r;
  logic wr_pend_r, preload_pend;
  logic [7:0] addr_r;
  cell_array_pkg::mode_t mode;
  cell_array_pkg::pin_drive_t drive;
  logic [7:0] logic_val, data_val, en_val;
  logic clk_rise, oe_active;
  logic [7:0] fb_val;

  // decode the two global bits into one mode for all cells
  function automatic cell_array_pkg::mode_t decode_mode(input logic [1:0] g);
    if (g[cell_array_pkg::SYNC_BIT] == 1'b0) begin
      decode_mode = cell_array_pkg::MODE_REGISTERED;
    end else if (g[cell_array_pkg::MODE_BIT]) begin
      decode_mode = cell_array_pkg::MODE_COMPLEX;
    end else begin
      decode_mode = cell_array_pkg::MODE_SIMPLE;
    end
  endfunction

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    is_ofs = (a == o);
  endfunction

  assign mode = decode_mode(global_r);
  assign hreadyout = 1'b1; // zero wait states, writes land one cycle after address
  assign hresp = 1'b0;

  // capture the address phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // configuration register writes; only bits 0..7 are kept, bits 0..1 for the global register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_r <= cell_array_pkg::GLOBAL_RST;
      polarity_r <= cell_array_pkg::CELL_RST;
      direction_r <= cell_array_pkg::CELL_RST;
      drive_r <= cell_array_pkg::DRIVE_RST; // totem-pole default
      sum_r <= cell_array_pkg::CELL_RST;
      enable_r <= cell_array_pkg::CELL_RST;
    end else if (wr_pend_r) begin
      if (is_ofs(addr_r, cell_array_pkg::GLOBAL_OFS)) global_r <= hwdata[1:0];
      if (is_ofs(addr_r, cell_array_pkg::POLARITY_OFS)) polarity_r <= hwdata[7:0];
      if (is_ofs(addr_r, cell_array_pkg::DIRECTION_OFS)) direction_r <= hwdata[7:0];
      if (is_ofs(addr_r, cell_array_pkg::DRIVE_OFS)) drive_r <= hwdata[7:0];
      if (is_ofs(addr_r, cell_array_pkg::SUM_OFS)) sum_r <= hwdata[7:0];
      if (is_ofs(addr_r, cell_array_pkg::ENABLE_OFS)) enable_r <= hwdata[7:0];
    end
  end

  assign preload_pend = wr_pend_r && is_ofs(addr_r, cell_array_pkg::PRELOAD_OFS);

  // read mux, registered at the address phase so data is ready in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        cell_array_pkg::GLOBAL_OFS: hrdata <= {30'h0, global_r};
        cell_array_pkg::POLARITY_OFS: hrdata <= {24'h0, polarity_r};
        cell_array_pkg::DIRECTION_OFS: hrdata <= {24'h0, direction_r};
        cell_array_pkg::DRIVE_OFS: hrdata <= {24'h0, drive_r};
        cell_array_pkg::SUM_OFS: hrdata <= {24'h0, sum_r};
        cell_array_pkg::ENABLE_OFS: hrdata <= {24'h0, enable_r};
        cell_array_pkg::PRELOAD_OFS: hrdata <= {24'h0, cell_reg_r};
        cell_array_pkg::STATUS_OFS: hrdata <= {28'h0, ctl_s2_r, mode};
        cell_array_pkg::PINS_OFS: hrdata <= {24'h0, pins_s2_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // two-flop synchronisers for pins from outside the clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_s1_r <= 8'h00;
      pins_s2_r <= 8'h00;
      ctl_s1_r <= 2'h3;
      ctl_s2_r <= 2'h3;
      ctl_d_r <= 2'h3;
    end else begin
      pins_s1_r <= cell_pin_in;
      pins_s2_r <= pins_s1_r;
      ctl_s1_r <= {shared_oe_n_pin, shared_clk_pin};
      ctl_s2_r <= ctl_s1_r;
      ctl_d_r <= ctl_s2_r;
    end
  end

  // the shared clock pin's rising edge, only meaningful in registered mode
  assign clk_rise = ctl_s2_r[0] && !ctl_d_r[0] &&
                    (mode == cell_array_pkg::MODE_REGISTERED);
  assign oe_active = !ctl_s2_r[1]; // active low shared enable

  // output registers: cleared at reset, preloaded by write, sampled on a shared clock rise, else held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_reg_r <= cell_array_pkg::CELL_RST;
    end else if (preload_pend) begin
      cell_reg_r <= hwdata[7:0]; // preload wins over a clock edge
    end else if (clk_rise) begin
      cell_reg_r <= sum_r ^ term_sum; // eight-term sum captured
    end
  end

  // logic value per cell; the sum input and soft sum are xored so either can drive it
  // direction bit set means input for the simple mode except the centre cells 3 and 4, and io for registered mode
  always_comb begin
    logic_val = 8'h00;
    en_val = 8'h00;
    for (int i = 0; i < cell_array_pkg::NUM_CELLS; i++) begin
      case (mode)
        cell_array_pkg::MODE_REGISTERED: begin
          if (!direction_r[i]) begin
            logic_val[i] = cell_reg_r[i]; // registered cell
            en_val[i] = oe_active;
          end else begin
            logic_val[i] = sum_r[i] ^ term_sum[i]; // seven terms
            en_val[i] = enable_r[i] | term_enable[i]; // eighth term is the enable
          end
        end
        cell_array_pkg::MODE_COMPLEX: begin
          logic_val[i] = sum_r[i] ^ term_sum[i];
          en_val[i] = enable_r[i] | term_enable[i];
        end
        cell_array_pkg::MODE_SIMPLE: begin
          logic_val[i] = sum_r[i] ^ term_sum[i];
          en_val[i] = !direction_r[i] || i == cell_array_pkg::CENTRE_LO ||
                      i == cell_array_pkg::CENTRE_HI;
        end
        default: begin
          logic_val[i] = 1'b0;
          en_val[i] = 1'b0;
        end
      endcase
    end
  end

  // polarity and drive type; open-drain only drives low
  always_comb begin
    data_val = logic_val ^ polarity_r;
    for (int i = 0; i < cell_array_pkg::NUM_CELLS; i++) begin
      drive.out[i] = drive_r[i] ? 1'b0 : data_val[i];
      drive.oe[i] = drive_r[i] ? (en_val[i] && !data_val[i]) : en_val[i];
    end
  end

  // feedback routing into the array per mode
  always_comb begin
    fb_val = 8'h00;
    case (mode)
      cell_array_pkg::MODE_REGISTERED: begin
        fb_val = pins_s2_r;
        for (int i = 0; i < cell_array_pkg::NUM_CELLS; i++) begin
          if (!direction_r[i]) fb_val[i] = cell_reg_r[i];
        end
      end
      cell_array_pkg::MODE_COMPLEX: begin
        fb_val = pins_s2_r;
        fb_val[cell_array_pkg::OUTER_HI] = ctl_s2_r[0];
        fb_val[cell_array_pkg::OUTER_LO] = ctl_s2_r[1];
      end
      cell_array_pkg::MODE_SIMPLE: begin
        // each pin except the centre pins 3 and 4 feeds the array through its neighbour's path
        for (int i = 0; i < cell_array_pkg::NUM_CELLS; i++) begin
          fb_val[i ^ 1] = pins_s2_r[i];
        end
        fb_val[cell_array_pkg::CENTRE_LO ^ 1] = 1'b0;
        fb_val[cell_array_pkg::CENTRE_HI ^ 1] = 1'b0;
      end
      default: fb_val = 8'h00;
    endcase
  end

  // outputs: pins combinational from config, data lanes held steady by registers
  always_comb begin
    cell_pin_out = drive.out;
    cell_pin_oe = drive.oe;
    if (mode == cell_array_pkg::MODE_COMPLEX) begin
      // outer cells have no input path; still outputs
      cell_pin_oe = drive.oe;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_feedback <= 8'h00;
      array_extra_in <= 2'h0;
    end else begin
      array_feedback <= fb_val;
      // clock/enable pins feed the array except in registered mode
      array_extra_in <= (mode == cell_array_pkg::MODE_REGISTERED) ? 2'h0 : ctl_s2_r;
    end
  end

  // output registers: capture on the shared clock, preload, otherwise hold
  // preload is checked on its own because it wins over a coincident clock edge
  reg_capture_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_rise && !preload_pend |=> cell_reg_r == $past(sum_r ^ term_sum))
    else $error("register missed shared clock edge");
  preload_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    preload_pend |=> cell_reg_r == $past(hwdata[7:0]))
    else $error("preload not applied");
  hold_noclk_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !clk_rise && !preload_pend |=> $stable(cell_reg_r))
    else $error("register changed without clock");
  // the clock pin is plain data outside registered mode
  no_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode != cell_array_pkg::MODE_REGISTERED |-> !clk_rise)
    else $error("clock edge outside registered mode");

  // the global bits pick one mode for every cell; sync bit low means registered
  mode_reg_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !global_r[cell_array_pkg::SYNC_BIT] |-> mode == cell_array_pkg::MODE_REGISTERED)
    else $error("registered mode not decoded");
  mode_complex_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    global_r[cell_array_pkg::SYNC_BIT] && global_r[cell_array_pkg::MODE_BIT] |->
      mode == cell_array_pkg::MODE_COMPLEX)
    else $error("complex mode not decoded");
  mode_simple_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    global_r[cell_array_pkg::SYNC_BIT] && !global_r[cell_array_pkg::MODE_BIT] |->
      mode == cell_array_pkg::MODE_SIMPLE)
    else $error("simple mode not decoded");

  // registered mode: one shared enable pin for register cells, a term for io cells
  // a few cells stand for the rest to keep the property count small
  shared_oe_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_REGISTERED && !direction_r[0] && !drive_r[0] &&
    ctl_s2_r[1] |-> !cell_pin_oe[0])
    else $error("registered output driven while enable high");
  oe_follows_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_REGISTERED && !direction_r[4] && !drive_r[4] |->
      cell_pin_oe[4] == !ctl_s2_r[1])
    else $error("registered output ignores shared enable");
  reg_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_REGISTERED && !direction_r[2] && !drive_r[2] |->
      cell_pin_out[2] == (cell_reg_r[2] ^ polarity_r[2]))
    else $error("registered cell not showing its register");
  io_enable_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_REGISTERED && direction_r[5] && !drive_r[5] |->
      cell_pin_oe[5] == (enable_r[5] | term_enable[5]))
    else $error("io cell enable term not applied");
  extra_in_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_REGISTERED |=> array_extra_in == 2'h0 || $changed(global_r))
    else $error("reserved pins reached array");

  // drive type and polarity apply in every mode
  polarity_inv_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !drive_r[1] |-> cell_pin_out[1] == (logic_val[1] ^ polarity_r[1]))
    else $error("polarity not applied");
  open_drain_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    drive_r[2] |-> cell_pin_out[2] == 1'b0)
    else $error("open drain drove high");
  totem_drive_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !drive_r[5] |->
      cell_pin_out[5] == data_val[5] && cell_pin_oe[5] == en_val[5])
    else $error("totem-pole cell not driving both levels");
  // complex and simple modes: enable term per cell, or fixed roles
  cplx_enable_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_COMPLEX && !drive_r[6] |->
      cell_pin_oe[6] == (enable_r[6] | term_enable[6]))
    else $error("complex enable term not applied");
  centre_on_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_SIMPLE && !drive_r[3] |-> cell_pin_oe[3])
    else $error("centre cell not driving");
  simple_input_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_SIMPLE && direction_r[1] |-> !cell_pin_oe[1])
    else $error("simple input cell drove its pin");
  simple_output_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_SIMPLE && !direction_r[6] && !drive_r[6] |->
      cell_pin_oe[6])
    else $error("simple output cell not always enabled");

  // feedback and extra inputs reach the array one cycle after the mode is seen
  // that cycle of latency keeps the array inputs glitch free across mode writes
  outer_fb_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_COMPLEX |=>
      array_feedback[7] == $past(ctl_s2_r[0]) && array_feedback[0] == $past(ctl_s2_r[1]))
    else $error("clock or enable pin missing from outer feedback");
  simple_swap_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_SIMPLE |=>
      array_feedback[0] == $past(pins_s2_r[1]) && array_feedback[7] == $past(pins_s2_r[6]))
    else $error("simple feedback not swapped with neighbour");
  centre_nofb_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == cell_array_pkg::MODE_SIMPLE |=>
      array_feedback[2] == 1'b0 && array_feedback[5] == 1'b0)
    else $error("centre cell fed back into array");
  extra_data_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode != cell_array_pkg::MODE_REGISTERED |=> array_extra_in == $past(ctl_s2_r))
    else $error("clock or enable pin not fed as data");
endmodule

// *** sim/board_logic_model.sv ***
// Purpose: board logic on the far side of the cell pins and the shared clock pin
// Assumes: every cell pin has a board pull-up; the shared clock pin idles low
// Notes: the bench tells the model which pins to drive and with what level
`timescale 1ns/1ps
module board_logic_model (
  input wire logic hclk,
  input wire logic [7:0] cell_pin_out,
  input wire logic [7:0] cell_pin_oe,
  input wire logic [7:0] drive_val,
  input wire logic [7:0] drive_en,
  output logic [7:0] cell_pin_in,
  output logic shared_clk_pin
);
  initial begin
    shared_clk_pin = 1'b0;
  end

  // wire level: the device wins while enabled; a released pin takes the bench level where driven, else the pull-up
  assign cell_pin_in = (cell_pin_oe & cell_pin_out) | (~cell_pin_oe & drive_en & drive_val) |
                       (~cell_pin_oe & ~drive_en);

  // one clean pulse, wide enough for the two-flop sampling to see both edges
  task automatic clk_pulse();
    @(posedge hclk);
    shared_clk_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    shared_clk_pin <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask

  // static level, used when the clock pin acts as a plain data input
  task automatic set_clk(input logic v);
    @(posedge hclk);
    shared_clk_pin <= v;
  endtask
endmodule

// *** sim/output_cell_array_test.sv ***
// Purpose: self-checking bench for the output cell array
// Assumes: one AHB-Lite master, board model on the pins, hclk 25 MHz
// Notes: pin inputs pass two sync flops, so six cycles are allowed to settle
`timescale 1ns/1ps
module output_cell_array_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, shared_oe_n_pin, shared_clk_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, array_extra_in;
  logic [2:0] hsize;
  logic [7:0] term_sum, term_enable, cell_pin_in, cell_pin_out, cell_pin_oe, array_feedback;
  logic [7:0] drive_val, drive_en;
  logic [1:0] mexp [4];
  int fail_count, comparisons;

  assign hready = hreadyout; // the only slave on the bus

  output_cell_array i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .term_sum(term_sum),
    .term_enable(term_enable), .shared_clk_pin(shared_clk_pin),
    .shared_oe_n_pin(shared_oe_n_pin), .cell_pin_in(cell_pin_in), .cell_pin_out(cell_pin_out),
    .cell_pin_oe(cell_pin_oe), .array_feedback(array_feedback), .array_extra_in(array_extra_in));

  board_logic_model i_board (.hclk(hclk), .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe),
    .drive_val(drive_val), .drive_en(drive_en), .cell_pin_in(cell_pin_in),
    .shared_clk_pin(shared_clk_pin));

  // clock generator
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // one single-word transfer; waits on hready in both phases, never a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_sim();
  end

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {term_sum, term_enable, drive_val, drive_en} = '0;
    shared_oe_n_pin = 1'b1;
    hresetn = 1'b0;
    mexp = '{cell_array_pkg::MODE_REGISTERED, cell_array_pkg::MODE_SIMPLE,
             cell_array_pkg::MODE_REGISTERED, cell_array_pkg::MODE_COMPLEX};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // reset state, unmapped place
    rdchk("global", cell_array_pkg::GLOBAL_OFS, 32'h0);
    rdchk("preload", cell_array_pkg::PRELOAD_OFS, 32'h0);
    chk("oe_reset", 32'h0, {24'h0, cell_pin_oe});
    wr(8'h40, 32'hffffffff);
    rdchk("unmapped", 8'h40, 32'h0);
    // every combination of the two global bits
    for (int m = 0; m < 4; m++) begin
      wr(cell_array_pkg::GLOBAL_OFS, m);
      rdchk("mode", cell_array_pkg::STATUS_OFS, {28'h0, 2'b10, mexp[m]});
    end
    // simple mode: always enabled, polarity, open drain, centre cells, feedback swap
    wr(cell_array_pkg::GLOBAL_OFS, 32'h1);
    wr(cell_array_pkg::POLARITY_OFS, 32'h0f);
    term_sum <= 8'h5a;
    settle();
    chk("simple_out", 32'h55, {24'h0, cell_pin_out});
    chk("simple_oe", 32'hff, {24'h0, cell_pin_oe});
    wr(cell_array_pkg::DRIVE_OFS, 32'hff);
    settle();
    chk("open_drain_oe", 32'haa, {24'h0, cell_pin_oe});
    wr(cell_array_pkg::DRIVE_OFS, 32'h0);
    drive_en <= 8'hff;
    drive_val <= 8'h96;
    wr(cell_array_pkg::DIRECTION_OFS, 32'hff);
    settle();
    chk("centre_oe", 32'h18, {24'h0, cell_pin_oe});
    chk("simple_fb", 32'h49, {24'h0, array_feedback});
    chk("simple_extra", 32'h2, {30'h0, array_extra_in});
    // complex mode: enable terms, clock and enable pins through outer feedback
    wr(cell_array_pkg::GLOBAL_OFS, 32'h3);
    wr(cell_array_pkg::DIRECTION_OFS, 32'h7e);
    term_enable <= 8'h3c;
    shared_oe_n_pin <= 1'b0;
    i_board.set_clk(1'b1);
    settle();
    chk("complex_oe", 32'h3c, {24'h0, cell_pin_oe});
    chk("complex_fb", 32'h2, {30'h0, array_feedback[7], array_feedback[0]});
    chk("complex_extra", 32'h1, {30'h0, array_extra_in});
    i_board.set_clk(1'b0);
    // registered mode: preload, shared clock, shared enable, mixed cells
    wr(cell_array_pkg::GLOBAL_OFS, 32'h0);
    wr(cell_array_pkg::DIRECTION_OFS, 32'hf0);
    wr(cell_array_pkg::POLARITY_OFS, 32'h0);
    wr(cell_array_pkg::PRELOAD_OFS, 32'ha5);
    rdchk("preload_rd", cell_array_pkg::PRELOAD_OFS, 32'ha5);
    term_sum <= 8'h3c;
    term_enable <= 8'h50;
    settle();
    chk("preload_pins", 32'h5, {28'h0, cell_pin_out[3:0]});
    chk("reg_oe", 32'h5f, {24'h0, cell_pin_oe});
    chk("reg_extra", 32'h0, {30'h0, array_extra_in});
    i_board.clk_pulse();
    settle();
    chk("captured", 32'hc, {28'h0, cell_pin_out[3:0]});
    wr(cell_array_pkg::POLARITY_OFS, 32'h0f);
    settle();
    chk("reg_polarity", 32'h3, {28'h0, cell_pin_out[3:0]});
    shared_oe_n_pin <= 1'b1;
    settle();
    chk("reg_disabled", 32'h0, {28'h0, cell_pin_oe[3:0]});
    // a second reset mid-run must clear the captured registers again
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("preload_rst", cell_array_pkg::PRELOAD_OFS, 32'h0);
    rdchk("global_rst", cell_array_pkg::GLOBAL_OFS, 32'h0);
    end_sim();
  end
endmodule
